// ### bench/mccs_chk_sva.sv
// Checker for the mode command decode timing
`timescale 1ns/1ps
module mccs_chk (
  // Clock and command
  input wire logic        clk_i,
  input wire logic        reset_i,
  input wire logic [23:0] cmd_word_i,
  input wire logic        cmd_done_i,
  // Decoded controls
  input wire logic        servo_cmd_rate_half_o,
  input wire logic        subcode_out_select_o,
  input wire logic        mult_osc_speed_double_o,
  input wire logic        wide_osc_speed_double_o,
  input wire logic [1:0]  mult_osc_sel_o,
  input wire logic        wide_osc_select_o,
  input wire logic        wide_osc_bypass_n_o,
  input wire logic        c2_quad_correct_o,
  input wire logic        double_speed_flag_o,
  // Resync sources and protected sync
  input wire logic        top_detect_signal_i,
  input wire logic        resync_pin_i,
  input wire logic        protected_subcode_sync_o
);
  wire logic [23:0] w = cmd_word_i;
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // Decoded value lands two edges after the word is taken
  sequence s_take; cmd_done_i ##2 1'b1; endsequence
  property p_rate; s_take |-> servo_cmd_rate_half_o == $past(w[18], 2);
  endproperty
  a_rate: assert property (p_rate) else $error("rate bad");
  property p_sub; s_take |-> subcode_out_select_o == $past(w[17], 2);
  endproperty
  a_sub: assert property (p_sub) else $error("sub bad");
  property p_msd;
    s_take |-> mult_osc_speed_double_o == $past(w[19] && !w[11:10], 2);
  endproperty
  a_msd: assert property (p_msd) else $error("msd bad");
  property p_wsd;
    s_take |-> wide_osc_speed_double_o == $past(w[16] && !w[8], 2);
  endproperty
  a_wsd: assert property (p_wsd) else $error("wsd bad");
  property p_msel; s_take |-> mult_osc_sel_o == $past(w[11:10], 2);
  endproperty
  a_msel: assert property (p_msel) else $error("msel bad");
  property p_wb;
    s_take |-> {wide_osc_bypass_n_o, wide_osc_select_o} == $past(w[9:8], 2);
  endproperty
  a_wb: assert property (p_wb) else $error("wide bad");
  property p_c2;
    s_take |-> {double_speed_flag_o, c2_quad_correct_o}
      == $past({w[22], !w[22] || w[7]}, 2);
  endproperty
  a_c2: assert property (p_c2) else $error("c2 bad");
  // A half-written word must never leak into the selection
  property p_hold; !$past(cmd_done_i, 2) |-> $stable(mult_osc_sel_o);
  endproperty
  a_hold: assert property (p_hold) else $error("sel moved");
  // Resync bit of the last word taken, so a 0 to 1 step can be seen
  logic last_d5;
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      last_d5 <= 1'b0;
    end else if (cmd_done_i) begin
      last_d5 <= cmd_word_i[5];
    end
  end
  sequence s_fld_rise; cmd_done_i && cmd_word_i[5] && !last_d5; endsequence
  sequence s_pin_resync; top_detect_signal_i || resync_pin_i; endsequence
  // Resync drops the lock, so no protected pulse once it has acted
  property p_fld_resync; s_fld_rise |-> ##3 !protected_subcode_sync_o;
  endproperty
  a_fld_resync: assert property (p_fld_resync) else $error("resync bad");
  property p_pin_resync; s_pin_resync |-> ##4 !protected_subcode_sync_o;
  endproperty
  a_pin_resync: assert property (p_pin_resync) else $error("pin bad");
endmodule
bind mccs_top mccs_chk u_mccs_chk (.*);

// ### bench/mccs_host.sv
// Host model: writes command words and supplies the read clock
`timescale 1ns/1ps
module mccs_host (
  // Clock and control
  input  wire logic        clk_i,
  input  wire logic        rd_en_i,
  // Toward the block
  output logic [23:0]      cmd_word_o,
  output logic             cmd_done_o,
  output logic             subcode_read_clock_o
);
  initial begin
    cmd_word_o = 24'h000000;
    cmd_done_o = 1'b0;
    subcode_read_clock_o = 1'b0;
  end
  // Read clock stands low outside readouts
  always @(negedge clk_i) begin
    subcode_read_clock_o <= rd_en_i & ~subcode_read_clock_o;
  end
  task send(input logic [23:0] wd);
    @(negedge clk_i);
    cmd_word_o = wd;
    cmd_done_o = 1'b1;
  endtask
  // Released word is inverted so stale bits never look valid
  task idle();
    @(negedge clk_i);
    cmd_done_o = 1'b0;
    cmd_word_o = ~cmd_word_o;
  endtask
endmodule

// ### bench/test_mode_command_clock_select.sv
// Self-checking bench for the mode command clock select block
`timescale 1ns/1ps
module test_mode_command_clock_select;
  logic        clk_i, reset_i, cmd_done_i, bit_clock_input_i, rd_en;
  logic [23:0] cmd_word_i, w;
  logic [3:0]  mult_osc_tick_i;
  logic [1:0]  wide_osc_tick_i, mult_osc_sel_o;
  logic        raw_subcode_sync_i, pcm_frame_i, top_detect_signal_i;
  logic        resync_pin_i, servo_filter_switch_i, subq_data_i;
  logic        monitor_data_i, subcode_read_clock_i, servo_cmd_rate_half_o;
  logic        subcode_out_select_o, mult_osc_speed_double_o;
  logic        wide_osc_speed_double_o, wide_osc_select_o;
  logic        wide_osc_bypass_n_o, c2_quad_correct_o, double_speed_flag_o;
  logic        mult_clk_tick_o, bit_clk_tick_o, subcode_serial_out_o;
  logic        sync_pin_o, protected_subcode_sync_o;
  int          bad_count, compares, cyc, m, b, p, s;
  mccs_top u_mccs_top (.*);
  mccs_host u_mccs_host (
    .clk_i                (clk_i),
    .rd_en_i              (rd_en),
    .cmd_word_o           (cmd_word_i),
    .cmd_done_o           (cmd_done_i),
    .subcode_read_clock_o (subcode_read_clock_i)
  );
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  task end_sim();
    if (bad_count == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task chk(input logic [3:0] g, input logic [3:0] e);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // Tick counts get one of slack for divider phase
  task chkn(input int g, input int e);
    compares++;
    if (g > e + 1 || g < e - 1) begin
      bad_count++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // Pulse counts must match exactly
  task chkp(input int g, input int e);
    compares++;
    if (g != e) begin
      bad_count++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // External bit clock toggles every cycle, so it rises every other one
  task cnt(input int n);
    m = 0;
    b = 0;
    p = 0;
    s = 0;
    repeat (n) begin
      @(negedge clk_i);
      bit_clock_input_i = ~bit_clock_input_i;
      m += int'(mult_clk_tick_o);
      b += int'(bit_clk_tick_o);
      p += int'(protected_subcode_sync_o);
      s += int'(sync_pin_o);
    end
  endtask
  // One raw sync edge, counting the protected pulses in the ten cycles after it
  task raw_hit();
    raw_subcode_sync_i = 1'b1;
    cnt(10);
    raw_subcode_sync_i = 1'b0;
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 6000) begin
      bad_count++;
      end_sim();
    end
  end
  initial begin
    reset_i = 1'b1;
    {rd_en, bit_clock_input_i, raw_subcode_sync_i, pcm_frame_i} = 4'h0;
    {top_detect_signal_i, resync_pin_i, servo_filter_switch_i} = 3'h0;
    {subq_data_i, monitor_data_i} = 2'h0;
    mult_osc_tick_i = 4'h0;
    wide_osc_tick_i = 2'h0;
    repeat (20) @(negedge clk_i);
    reset_i = 1'b0;
    chk(c2_quad_correct_o, 4'h1);
    chk(double_speed_flag_o, 4'h0);
    for (int i = 0; i < 8; i++) begin
      w = {1'b0, i[0], 3'h1, i[0], i[1], 1'b1, i[1:0], i[1:0], i[1:0],
           i[2], i[0], i[1], i[0], 6'h00};
      u_mccs_host.send(w);
      u_mccs_host.idle();
      repeat (2) @(negedge clk_i);
      chk(servo_cmd_rate_half_o, w[18]);
      chk(subcode_out_select_o, w[17]);
      chk(mult_osc_speed_double_o, i[1:0] == 0);
      chk(wide_osc_speed_double_o, !w[8]);
      chk(mult_osc_sel_o, w[11:10]);
      chk(wide_osc_bypass_n_o, w[9]);
      chk(wide_osc_select_o, w[8]);
      chk(c2_quad_correct_o, !w[22] | w[7]);
      chk(double_speed_flag_o, w[22]);
      mult_osc_tick_i = 4'h1 << i[1:0];
      wide_osc_tick_i = 2'h1 << i[0];
      cnt(64);
      chkn(m, 64 >> i[1:0]);
      chkn(b, w[9] ? 32 : 64 >> i[1:0]);
      mult_osc_tick_i = ~(4'h1 << i[1:0]);
      wide_osc_tick_i = ~(2'h1 << i[0]);
      cnt(16);
      chkn(m, 0);
      chkn(b, w[9] ? 8 : 0);
    end
    // Resync bit goes 0 then 1 in back-to-back words
    u_mccs_host.send(24'h000C00);
    u_mccs_host.send(24'h020060);
    u_mccs_host.idle();
    repeat (2) @(negedge clk_i);
    chk(mult_osc_sel_o, 4'h0);
    monitor_data_i = 1'b1;
    rd_en = 1'b1;
    repeat (12) @(negedge clk_i);
    chk(subcode_serial_out_o, 4'h1);
    rd_en = 1'b0;
    u_mccs_host.send(24'h000000);
    u_mccs_host.idle();
    subq_data_i = 1'b1;
    servo_filter_switch_i = 1'b1;
    repeat (6) @(negedge clk_i);
    chk(subcode_serial_out_o, 4'h1);
    chk(sync_pin_o, 4'h1);
    subq_data_i = 1'b0;
    servo_filter_switch_i = 1'b0;
    repeat (6) @(negedge clk_i);
    chk(subcode_serial_out_o, 4'h0);
    chk(sync_pin_o, 4'h0);
    // Protected sync: lock, free-run, ignore far edges, resync sources
    u_mccs_host.send(24'h000040);
    u_mccs_host.idle();
    pcm_frame_i = 1'b1;
    raw_hit();
    chkp(p, 1);
    chkp(s, 1);
    cnt(mccs_pkg::SYNC_PERIOD - 10);
    chkp(p, 0);
    cnt(10);
    chkp(p, 1);
    cnt(mccs_pkg::SYNC_PERIOD / 2);
    raw_hit();
    chkp(p, 0);
    top_detect_signal_i = 1'b1;
    cnt(4);
    top_detect_signal_i = 1'b0;
    raw_hit();
    chkp(p, 1);
    cnt(100);
    chkp(p, 0);
    resync_pin_i = 1'b1;
    cnt(4);
    resync_pin_i = 1'b0;
    raw_hit();
    chkp(p, 1);
    cnt(100);
    u_mccs_host.send(24'h000060);
    u_mccs_host.idle();
    raw_hit();
    chkp(p, 1);
    cnt(100);
    u_mccs_host.send(24'h000060);
    u_mccs_host.idle();
    raw_hit();
    chkp(p, 0);
    end_sim();
  end
endmodule

// ### hw/mccs_pkg.sv
// Constants and types for the mode command clock select block
// What this block does
// - Transfer-rate field halves servo command rate
// - Subcode select picks Sub Q or monitor
// - Mult speed-double only with low-speed oscillator
// - Mult divider codes give 1,2,4,8
// - Wide speed-double only with low-speed oscillator
// - Wide divider codes give 1,2,4,8
// - Mult select picks one of four oscillators
// - Bypass breaks internal wide-band bit clock
// - Wide select picks low or high oscillator
// - Correction field picks double or quadruple C2 at double speed
// - Sync select drives servo switch or protected
// - Resync only on field rising edge
// - Protected sync is dejittered, crystal-timed, aligned
// - Top detect or resync pin also resyncs
// - Double-speed flag selects playback speed
package mccs_pkg;
  localparam int CMD_W         = 24;
  localparam int POS_SPD_DBL   = 22;
  localparam int POS_MULT_SDBL = 19;
  localparam int POS_RATE_HALF = 18;
  localparam int POS_SUB_SEL   = 17;
  localparam int POS_WIDE_SDBL = 16;
  localparam int POS_MULT_DIV  = 14;
  localparam int POS_WIDE_DIV  = 12;
  localparam int POS_MULT_OSC  = 10;
  localparam int POS_BYPASS    = 9;
  localparam int POS_WIDE_OSC  = 8;
  localparam int POS_C2_QUAD   = 7;
  localparam int POS_SYNC_SEL  = 6;
  localparam int POS_RESYNC    = 5;
  localparam logic [23:0] CMD_RESET = 24'h000000;
  localparam int SYNC_PERIOD   = 1000;
  localparam int SYNC_WINDOW   = 16;
  localparam logic [3:0] DIV_EN_NONE = 4'h0;
  typedef enum logic [1:0] {
    MCCS_OSC_LOW  = 2'b00,
    MCCS_OSC_MID  = 2'b01,
    MCCS_OSC_HIGH = 2'b10,
    MCCS_OSC_4TH  = 2'b11
  } mccs_osc_t;
endpackage

// ### hw/mccs_postdiv.sv
// Post-divider by 1, 2, 4 or 8 giving a clock-enable pulse train
`timescale 1ns/1ps
module mccs_postdiv (
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  input  wire logic       src_i,
  input  wire logic [1:0] code_i,
  output logic            tick_o
);
  logic [2:0] cnt_reg;
  logic [2:0] lim;
  always_comb begin
    lim = 3'((4'h1 << code_i) - 4'h1);
  end
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cnt_reg <= 3'h0;
      tick_o  <= 1'b0;
    end else if (src_i) begin
      tick_o  <= (cnt_reg == 3'h0);
      cnt_reg <= (cnt_reg >= lim) ? 3'h0 : cnt_reg + 3'h1;
    end else begin
      tick_o  <= 1'b0;
    end
  end
endmodule

// ### hw/mccs_sync2.sv
// Two-flop synchroniser for one pin input
`timescale 1ns/1ps
module mccs_sync2 (
  input  wire logic clk_i,
  input  wire logic reset_i,
  input  wire logic d_i,
  output logic      q_o
);
  logic meta_reg;
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      meta_reg <= 1'b0;
      q_o      <= 1'b0;
    end else begin
      meta_reg <= d_i;
      q_o      <= meta_reg;
    end
  end
endmodule

// ### hw/mccs_top.sv
// Mode command decode, clock selection and protected subcode sync
`timescale 1ns/1ps
module mccs_top (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  // Command word from serial interface
  input  wire logic [23:0] cmd_word_i,
  input  wire logic        cmd_done_i,
  // Oscillator ticks and pins
  input  wire logic [3:0]  mult_osc_tick_i,
  input  wire logic [1:0]  wide_osc_tick_i,
  input  wire logic        bit_clock_input_i,
  input  wire logic        raw_subcode_sync_i,
  input  wire logic        pcm_frame_i,
  input  wire logic        top_detect_signal_i,
  input  wire logic        resync_pin_i,
  input  wire logic        servo_filter_switch_i,
  input  wire logic        subq_data_i,
  input  wire logic        monitor_data_i,
  input  wire logic        subcode_read_clock_i,
  // Decoded controls
  output logic             servo_cmd_rate_half_o,
  output logic             subcode_out_select_o,
  output logic             mult_osc_speed_double_o,
  output logic             wide_osc_speed_double_o,
  output logic [1:0]       mult_osc_sel_o,
  output logic             wide_osc_select_o,
  output logic             wide_osc_bypass_n_o,
  output logic             c2_quad_correct_o,
  output logic             double_speed_flag_o,
  // Clock and signal outputs
  output logic             mult_clk_tick_o,
  output logic             bit_clk_tick_o,
  output logic             subcode_serial_out_o,
  output logic             sync_pin_o,
  output logic             protected_subcode_sync_o
);
  import mccs_pkg::*;

  logic [23:0] cmd_reg;
  logic        resync_fld_prev_reg;
  logic        top_s;
  logic        rpin_s;
  logic        bclk_s;
  logic        rsync_s;
  logic        rsync_d_reg;
  logic        subcode_read_clock_s;
  logic        subcode_read_clock_d_reg;
  logic        resync_req;
  logic        mult_src;
  logic        wide_src;
  logic        wide_tick;
  logic        bclk_src;
  logic [9:0]  psync_cnt_reg;
  logic        psync_lock_reg;
  logic [9:0]  psync_cnt_next;
  logic        raw_edge;
  logic        c2_quad;

  mccs_sync2 u_sync_top (.clk_i(clk_i), .reset_i(reset_i),
    .d_i(top_detect_signal_i), .q_o(top_s));
  mccs_sync2 u_sync_rpin (.clk_i(clk_i), .reset_i(reset_i),
    .d_i(resync_pin_i), .q_o(rpin_s));
  mccs_sync2 u_sync_bclk (.clk_i(clk_i), .reset_i(reset_i),
    .d_i(bit_clock_input_i), .q_o(bclk_s));
  mccs_sync2 u_sync_raw (.clk_i(clk_i), .reset_i(reset_i),
    .d_i(raw_subcode_sync_i), .q_o(rsync_s));
  mccs_sync2 u_sync_subcode_read_clock (.clk_i(clk_i), .reset_i(reset_i),
    .d_i(subcode_read_clock_i), .q_o(subcode_read_clock_s));

  // Whole word latched at once so no mixed oscillator setup appears
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cmd_reg <= CMD_RESET;
    end else if (cmd_done_i) begin
      cmd_reg <= cmd_word_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      resync_fld_prev_reg <= 1'b0;
    end else begin
      resync_fld_prev_reg <= cmd_reg[POS_RESYNC];
    end
  end

  // Only a 0 to 1 step of the field counts; a held 1 does nothing
  assign resync_req = (cmd_reg[POS_RESYNC] & ~resync_fld_prev_reg)
                    | top_s | rpin_s;

  // Speed double honoured only with the low-speed oscillators
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      servo_cmd_rate_half_o   <= 1'b0;
      subcode_out_select_o    <= 1'b0;
      mult_osc_speed_double_o <= 1'b0;
      wide_osc_speed_double_o <= 1'b0;
      mult_osc_sel_o          <= 2'b00;
      wide_osc_select_o       <= 1'b0;
      wide_osc_bypass_n_o     <= 1'b0;
      double_speed_flag_o     <= 1'b0;
    end else begin
      servo_cmd_rate_half_o <= cmd_reg[POS_RATE_HALF];
      subcode_out_select_o  <= cmd_reg[POS_SUB_SEL];
      mult_osc_speed_double_o <= cmd_reg[POS_MULT_SDBL]
        & (cmd_reg[POS_MULT_OSC +: 2] == MCCS_OSC_LOW);
      wide_osc_speed_double_o <= cmd_reg[POS_WIDE_SDBL]
        & ~cmd_reg[POS_WIDE_OSC];
      mult_osc_sel_o      <= cmd_reg[POS_MULT_OSC +: 2];
      wide_osc_select_o   <= cmd_reg[POS_WIDE_OSC];
      wide_osc_bypass_n_o <= cmd_reg[POS_BYPASS];
      double_speed_flag_o <= cmd_reg[POS_SPD_DBL];
    end
  end

  // Normal speed always runs quadruple correction
  assign c2_quad = ~cmd_reg[POS_SPD_DBL] | cmd_reg[POS_C2_QUAD];

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      c2_quad_correct_o <= 1'b1;
    end else begin
      c2_quad_correct_o <= c2_quad;
    end
  end

  assign mult_src = mult_osc_tick_i[cmd_reg[POS_MULT_OSC +: 2]];
  assign wide_src = wide_osc_tick_i[cmd_reg[POS_WIDE_OSC]];

  mccs_postdiv u_mult_div (
    .clk_i  (clk_i),
    .reset_i(reset_i),
    .src_i  (mult_src),
    .code_i (cmd_reg[POS_MULT_DIV +: 2]),
    .tick_o (mult_clk_tick_o)
  );

  mccs_postdiv u_wide_div (
    .clk_i  (clk_i),
    .reset_i(reset_i),
    .src_i  (wide_src),
    .code_i (cmd_reg[POS_WIDE_DIV +: 2]),
    .tick_o (wide_tick)
  );

  // External bit clock only when the internal path is broken
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rsync_d_reg <= 1'b0;
      subcode_read_clock_d_reg  <= 1'b0;
    end else begin
      rsync_d_reg <= rsync_s;
      subcode_read_clock_d_reg  <= subcode_read_clock_s;
    end
  end

  logic bclk_d_reg;
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      bclk_d_reg <= 1'b0;
    end else begin
      bclk_d_reg <= bclk_s;
    end
  end

  assign bclk_src = cmd_reg[POS_BYPASS] ? (bclk_s & ~bclk_d_reg)
                                        : wide_tick;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      bit_clk_tick_o <= 1'b0;
    end else begin
      bit_clk_tick_o <= bclk_src;
    end
  end

  // Monitor data advances on host read clock edges
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      subcode_serial_out_o <= 1'b0;
    end else if (!cmd_reg[POS_SUB_SEL]) begin
      subcode_serial_out_o <= subq_data_i;
    end else if (subcode_read_clock_s & ~subcode_read_clock_d_reg) begin
      subcode_serial_out_o <= monitor_data_i;
    end
  end

  // Protected sync free-runs on the crystal; once locked, raw edges only re-align it
  // inside a small window, which filters their jitter.
  assign raw_edge = rsync_s & ~rsync_d_reg;

  always_comb begin
    if (psync_cnt_reg == 10'(SYNC_PERIOD - 1)) begin
      psync_cnt_next = 10'h000;
    end else begin
      psync_cnt_next = psync_cnt_reg + 10'h001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      psync_cnt_reg  <= 10'h000;
      psync_lock_reg <= 1'b0;
    end else if (resync_req) begin
      psync_lock_reg <= 1'b0;
    end else if (raw_edge && pcm_frame_i && !psync_lock_reg) begin
      psync_cnt_reg  <= 10'h000;
      psync_lock_reg <= 1'b1;
    end else if (raw_edge && pcm_frame_i &&
                 (psync_cnt_reg < 10'(SYNC_WINDOW) ||
                  psync_cnt_reg > 10'(SYNC_PERIOD - SYNC_WINDOW))) begin
      psync_cnt_reg <= 10'h000;
    end else begin
      psync_cnt_reg <= psync_cnt_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      protected_subcode_sync_o <= 1'b0;
    end else begin
      protected_subcode_sync_o <= psync_lock_reg
                                & (psync_cnt_reg == 10'h000);
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      sync_pin_o <= 1'b0;
    end else if (cmd_reg[POS_SYNC_SEL]) begin
      sync_pin_o <= psync_lock_reg & (psync_cnt_reg == 10'h000);
    end else begin
      sync_pin_o <= servo_filter_switch_i;
    end
  end
endmodule
